// File: verilog/sfr_consts.svh
// Purpose: shared constants for the core special function register block
// Assumes: 10-bit data memory address, sector in bits 9:8, byte in 7:0
// Notes: apb byte address is four times the data memory address
//
// Behaviour
// - instructions on an indirect port act on the pointer-addressed location
// - port a with its one-byte pointer reaches sector 0 only
// - ports b and c use sector byte plus low byte, any sector
// - indirect ports read as 00h and ignore writes as plain registers
// - five pointer registers behave as ordinary read/write/arith registers
// - extended direct access reaches every sector, sector high, byte low
// - accumulator holds alu results; no register-to-register move exists
// - writing pc low byte jumps within the current page
// - a pc low byte jump inserts one dummy cycle
// - two table pointers form the table read program address
// - table read latches high byte, stores low byte to named location
// - extended address operand has 10 valid bits, sector and byte
// - unused special locations read as 00h
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// ----------------------------------------------------------------------
// widths and fields
// ----------------------------------------------------------------------
`define M_W 10
`define SEC_MSB 9
`define SEC_LSB 8
`define RAM_BIT 7
`define RAM_AW 8
`define RAM_DEPTH 256
`define SECTORS8 8'h02
`define SECTORS2 2'h2
`define SECTOR0 2'h0
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define ONE8 8'h01
`define ONE16 16'h0001
`define SEC_W 2
`define PAGE_MSB 15
`define PAGE_LSB 8
`define PADDR_MSB 11
`define PADDR_LSB 2

// ----------------------------------------------------------------------
// sector 0 special locations
// ----------------------------------------------------------------------
`define IDX_PORT_A 8'h00
`define IDX_PTR_A 8'h01
`define IDX_PORT_B 8'h02
`define IDX_PB_LOW 8'h03
`define IDX_PB_SEC 8'h04
`define IDX_ACC 8'h05
`define IDX_PC_LOW 8'h06
`define IDX_TP_LOW 8'h07
`define IDX_TD_HIGH 8'h08
`define IDX_TP_HIGH 8'h09
`define IDX_PORT_C 8'h0c
`define IDX_PC_LOW_C 8'h0d
`define IDX_PC_SEC_C 8'h0e
`define IDX_CMD 8'h76
`define IDX_OPER_LO 8'h77
`define IDX_OPER_SEC 8'h78
`define IDX_PC_HIGH 8'h79

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define OP_LOAD 8'h01
`define OP_STORE 8'h02
`define OP_ADD 8'h03
`define OP_INC 8'h04
`define OP_DEC 8'h05
`define OP_CLR 8'h06
`define OP_TABRD 8'h07

`endif

// File: verilog/sfr_pkg.sv
// Purpose: types for the core special function register block
// Assumes: constants come from sfr_consts.svh
// Notes: none
`include "sfr_consts.svh"

package sfr_pkg;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_fetch, st_exec} state_t;

  typedef struct packed {
    logic ok;
    logic [`M_W-1:0] addr;
  } mem_ref_t;

  typedef struct packed {
    logic en;
    logic [`M_W-1:0] addr;
    logic [7:0] data;
  } wr_req_t;

endpackage : sfr_pkg

// File: verilog/sfr_core.sv
// Purpose: indirect ports, pointers, accumulator, pc low byte, table regs
// Assumes: apb slave, data memory address m sits at byte address m*4
// Notes: commands model instructions; apb access is plain register access
//   only two sectors are implemented; higher sectors read as zero
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "sfr_consts.svh"

module sfr_core
  import sfr_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic pc_advance,
  output logic [15:0] pc,
  output logic pc_dummy,
  output logic [15:0] tbl_addr,
  input wire logic [15:0] tbl_word
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  state_t state;
  logic [7:0] pointer_a;
  logic [7:0] pointer_b_low;
  logic [7:0] pointer_b_sector;
  logic [7:0] pointer_c_low;
  logic [7:0] pointer_c_sector;
  logic [7:0] acc;
  logic [7:0] table_data_high;
  logic [7:0] cmd_op;
  logic [7:0] oper_lo;
  logic [1:0] oper_sec;
  logic [7:0] ram [`RAM_DEPTH];

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  wire busy = (state != st_idle);
  wire [`M_W-1:0] apb_m = paddr[`PADDR_MSB:`PADDR_LSB];
  wire apb_take = psel & penable & ~pready & ~busy;
  wire apb_commit = psel & penable & pready;
  wire apb_wr = apb_commit & pwrite;
  wire [7:0] pc_low_byte = pc[7:0];
  wire [7:0] table_ptr_low = tbl_addr[7:0];
  wire [7:0] table_ptr_high = tbl_addr[15:8];
  wire [`M_W-1:0] cmd_m = {oper_sec, oper_lo};
  wire cmd_in_s0 = (oper_sec == `SECTOR0);
  wire launch = apb_wr && (apb_m[`SEC_MSB:`SEC_LSB] == `SECTOR0)
    && (apb_m[7:0] == `IDX_CMD);
  wire op_tab = (cmd_op == `OP_TABRD);
  wire exec = (state == st_exec);
  wire hit_port_a = cmd_in_s0 && (oper_lo == `IDX_PORT_A);
  wire hit_port_b = cmd_in_s0 && (oper_lo == `IDX_PORT_B);
  wire hit_port_c = cmd_in_s0 && (oper_lo == `IDX_PORT_C);

  // --------------------------------------------------------------------
  // field slices
  // --------------------------------------------------------------------
  wire [`SEC_W-1:0] ptr_b_sec = pointer_b_sector[`SEC_W-1:0];
  wire [`SEC_W-1:0] ptr_c_sec = pointer_c_sector[`SEC_W-1:0];
  wire [7:0] pc_page = pc[`PAGE_MSB:`PAGE_LSB];

  // --------------------------------------------------------------------
  // pointer resolution for commands
  // --------------------------------------------------------------------
  mem_ref_t cmd_ref;
  // the full sector byte is range checked: slicing it alone would let a
  // too-high sector alias onto a low one
  always_comb begin
    cmd_ref.ok = 1'b1;
    cmd_ref.addr = cmd_m; // direct form reaches any sector
    if (hit_port_a) begin
      // one-byte pointer, sector 0 only
      cmd_ref.addr = {`SECTOR0, pointer_a};
    end else if (hit_port_b) begin
      cmd_ref.ok = (pointer_b_sector < `SECTORS8);
      cmd_ref.addr = {ptr_b_sec, pointer_b_low};
    end else if (hit_port_c) begin
      cmd_ref.ok = (pointer_c_sector < `SECTORS8);
      cmd_ref.addr = {ptr_c_sec, pointer_c_low};
    end
  end

  // --------------------------------------------------------------------
  // single read port; apb never reads while a command runs
  // --------------------------------------------------------------------
  wire [`M_W-1:0] rd_m = busy ? cmd_ref.addr : apb_m;
  wire rd_ok = busy ? cmd_ref.ok : 1'b1;
  wire rd_s0 = (rd_m[`SEC_MSB:`SEC_LSB] == `SECTOR0);
  wire rd_ram = rd_m[`RAM_BIT] && (rd_m[`SEC_MSB:`SEC_LSB] < `SECTORS2);
  wire [`RAM_AW-1:0] rd_idx = {rd_m[`SEC_LSB], rd_m[6:0]};
  logic [7:0] sfr_rd;
  logic [7:0] rd_val;

  always_comb begin
    // ports have no storage and unused slots are empty
    // bus reads never resolve pointers; only commands do
    sfr_rd = `ZERO8;
    case (rd_m[7:0])
      `IDX_PTR_A: sfr_rd = pointer_a;
      `IDX_PB_LOW: sfr_rd = pointer_b_low;
      `IDX_PB_SEC: sfr_rd = pointer_b_sector;
      `IDX_ACC: sfr_rd = acc;
      `IDX_PC_LOW: sfr_rd = pc_low_byte;
      `IDX_TP_LOW: sfr_rd = table_ptr_low;
      `IDX_TD_HIGH: sfr_rd = table_data_high;
      `IDX_TP_HIGH: sfr_rd = table_ptr_high;
      `IDX_PC_LOW_C: sfr_rd = pointer_c_low;
      `IDX_PC_SEC_C: sfr_rd = pointer_c_sector;
      `IDX_CMD: sfr_rd = {7'h00, busy};
      `IDX_OPER_LO: sfr_rd = oper_lo;
      `IDX_OPER_SEC: sfr_rd = {6'h00, oper_sec};
      `IDX_PC_HIGH: sfr_rd = pc_page;
      default: sfr_rd = `ZERO8;
    endcase
  end

  always_comb begin
    rd_val = `ZERO8;
    if (!rd_ok) begin
      rd_val = `ZERO8;
    end else if (rd_ram) begin
      rd_val = ram[rd_idx];
    end else if (rd_s0) begin
      rd_val = sfr_rd;
    end
  end

  // --------------------------------------------------------------------
  // single write path shared by apb and commands
  // --------------------------------------------------------------------
  // rmw commands read and write the same resolved address
  // a store or step aimed at the pc low byte is a jump like a bus write
  wr_req_t wr;
  always_comb begin
    wr.en = 1'b0;
    wr.addr = apb_m;
    wr.data = pwdata[7:0];
    if (exec) begin
      wr.addr = cmd_ref.addr;
      wr.en = cmd_ref.ok;
      case (cmd_op)
        `OP_STORE: wr.data = acc;
        `OP_INC: wr.data = rd_val + `ONE8;
        `OP_DEC: wr.data = rd_val - `ONE8;
        `OP_CLR: wr.data = `ZERO8;
        `OP_TABRD: wr.data = tbl_word[7:0];
        default: wr.en = 1'b0;
      endcase
    end else if (apb_wr) begin
      wr.en = 1'b1;
    end
  end

  wire wr_s0 = (wr.addr[`SEC_MSB:`SEC_LSB] == `SECTOR0);
  wire wr_ram = wr.addr[`RAM_BIT]
    && (wr.addr[`SEC_MSB:`SEC_LSB] < `SECTORS2);
  wire wr_sfr = wr.en && wr_s0 && !wr.addr[`RAM_BIT];
  wire [7:0] wr_i = wr.addr[7:0];
  wire [`RAM_AW-1:0] wr_idx = {wr.addr[`SEC_LSB], wr.addr[6:0]};
  wire acc_alu = exec && ((cmd_op == `OP_LOAD) || (cmd_op == `OP_ADD));
  wire pc_jump = wr_sfr && (wr_i == `IDX_PC_LOW);

  // --------------------------------------------------------------------
  // command sequencer
  // --------------------------------------------------------------------
  state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (launch) begin
          next_state = (pwdata[7:0] == `OP_TABRD) ? st_fetch : st_exec;
        end
      end
      st_fetch: next_state = st_exec; // table address settles
      // other op codes still spend one exec cycle and change nothing
      st_exec: next_state = st_idle;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= st_idle;
      cmd_op <= `ZERO8;
    end else if (ce) begin
      state <= next_state;
      if (launch) begin
        cmd_op <= pwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // apb answer: data ready one cycle into the access phase
  // --------------------------------------------------------------------
  // limitation: ce low while pready stands freezes the answer, but the
  // master may still take it, so keep ce high across a transfer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apb_take;
      if (apb_take && !pwrite) begin
        prdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // --------------------------------------------------------------------
  // data memory
  // --------------------------------------------------------------------
  // no reset: general memory powers up undefined
  // index is the sector bit over the low seven bits; high halves only
  always_ff @(posedge ref_clk) begin
    if (ce && wr.en && wr_ram) begin
      ram[wr_idx] <= wr.data;
    end
  end

  // --------------------------------------------------------------------
  // pointer and table registers
  // --------------------------------------------------------------------
  // writes to port slots fall through untouched
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pointer_a <= `ZERO8;
      pointer_b_low <= `ZERO8;
      pointer_b_sector <= `ZERO8;
      pointer_c_low <= `ZERO8;
      pointer_c_sector <= `ZERO8;
      tbl_addr <= `ZERO16;
      oper_lo <= `ZERO8;
      oper_sec <= `SECTOR0;
    end else if (ce && wr_sfr) begin
      case (wr_i)
        `IDX_PTR_A: pointer_a <= wr.data;
        `IDX_PB_LOW: pointer_b_low <= wr.data;
        `IDX_PB_SEC: pointer_b_sector <= wr.data;
        `IDX_PC_LOW_C: pointer_c_low <= wr.data;
        `IDX_PC_SEC_C: pointer_c_sector <= wr.data;
        `IDX_TP_LOW: tbl_addr[7:0] <= wr.data;
        `IDX_TP_HIGH: tbl_addr[15:8] <= wr.data;
        `IDX_OPER_LO: oper_lo <= wr.data;
        `IDX_OPER_SEC: oper_sec <= wr.data[`SEC_W-1:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // accumulator and table latch
  // --------------------------------------------------------------------
  // only load, add, store and table read move data; no memory-to-memory op exists
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc <= `ZERO8;
      table_data_high <= `ZERO8;
    end else if (ce) begin
      if (acc_alu) begin
        acc <= (cmd_op == `OP_ADD) ? acc + rd_val : rd_val;
      end else if (wr_sfr && (wr_i == `IDX_ACC)) begin
        acc <= wr.data;
      end
      if (exec && op_tab) begin
        table_data_high <= tbl_word[15:8];
      end
    end
  end

  // --------------------------------------------------------------------
  // program counter
  // --------------------------------------------------------------------
  // page bits are kept, so a jump never leaves the page; the dummy cycle
  // blocks one advance, which the core uses to flush the fetched word
  // a jump write wins over an advance in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc <= `ZERO16;
      pc_dummy <= 1'b0;
    end else if (ce) begin
      pc_dummy <= pc_jump;
      if (pc_jump) begin
        pc <= {pc_page, wr.data};
      end else if (pc_advance && !pc_dummy) begin
        pc <= pc + `ONE16;
      end
    end
  end

endmodule : sfr_core

// File: dv/sfr_core_sva.sv
// Purpose: rule checker for sfr_core, ports only
// Assumes: byte address is four times the data memory address
// Notes: one clock domain
`timescale 1ns/1ps

module sfr_core_sva
  import sfr_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic pc_advance,
  input wire logic [15:0] pc,
  input wire logic pc_dummy,
  input wire logic [15:0] tbl_addr,
  input wire logic [15:0] tbl_word
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [9:0] m;
  logic [7:0] pc_hi;
  logic [7:0] wlo;
  logic wr_done;
  logic rd_done;
  logic jump;
  assign m = paddr[11:2];
  assign pc_hi = pc[15:8];
  assign wlo = pwdata[7:0];
  assign wr_done = ce && psel && penable && pready && pwrite;
  assign rd_done = ce && psel && penable && pready && !pwrite;
  assign jump = wr_done && m == 10'h006;
  port_zero_a: assert property (rd_done && (m == 10'h000 ||
    m == 10'h002 || m == 10'h00c) |-> prdata == 32'h0)
    else $error("indirect port read not zero");
  unused_zero_a: assert property (rd_done && m == 10'h00a
    |-> prdata == 32'h0 && !pslverr) else $error("unused read not zero");
  high_sector_a: assert property (rd_done && m[9]
    |-> prdata == 32'h0) else $error("sector above 1 read not zero");
  jump_page_a: assert property (jump
    |=> pc == {$past(pc_hi), $past(wlo)}) else $error("jump left page");
  dummy_once_a: assert property (jump
    |=> pc_dummy ##1 !pc_dummy) else $error("dummy cycle missing");
  dummy_hold_a: assert property (pc_dummy |=> $stable(pc))
    else $error("pc moved in dummy cycle");
  pc_step_a: assert property (ce && pc_advance && !pc_dummy && !jump
    |=> pc == $past(pc) + 16'h0001) else $error("pc did not step");
  tptr_low_a: assert property (wr_done && m == 10'h007
    |=> tbl_addr[7:0] == $past(wlo)) else $error("table low not loaded");
  tptr_high_a: assert property (wr_done && m == 10'h009
    |=> tbl_addr[15:8] == $past(wlo)) else $error("table high not loaded");
  cover property (pc_dummy);
  cover property (wr_done && m == 10'h076);
  cover property (rd_done && m[8]);
endmodule : sfr_core_sva

bind sfr_core sfr_core_sva i_sfr_core_sva (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pc_advance(pc_advance), .pc(pc),
  .pc_dummy(pc_dummy), .tbl_addr(tbl_addr), .tbl_word(tbl_word));

// File: dv/tb_top.sv
// Purpose: self-checking bench for sfr_core
// Assumes: apb stalls while a command runs, so a read waits for it
// Notes: commands at 0x076 stand in for instructions
`timescale 1ns/1ps
`include "sfr_consts.svh"

module tb_top
  import sfr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pc_advance = 1'b0;
  logic [15:0] tbl_word = 16'h0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pc_dummy;
  logic [15:0] pc;
  logic [15:0] tbl_addr;
  logic [15:0] got;
  logic [7:0] hi;
  int n_fail = 0;
  int comparisons = 0;

  sfr_core i_sfr_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pc_advance(pc_advance), .pc(pc), .pc_dummy(pc_dummy),
    .tbl_addr(tbl_addr), .tbl_word(tbl_word));

  initial forever #2 ref_clk = ~ref_clk;
  // program word is a fixed scramble of its address
  always @(posedge ref_clk) tbl_word <= tbl_addr ^ 16'hc3a5;

  // ----------------------------------------------------------------
  // bus and report tasks
  // ----------------------------------------------------------------
  task conclude;
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task xfer(input logic wr, input logic [9:0] m, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {m, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    got = prdata[15:0];
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
  endtask : xfer

  task wr(input logic [9:0] m, input logic [7:0] d);
    xfer(1'b1, m, d);
  endtask : wr

  task rd(input logic [9:0] m, input logic [7:0] e);
    xfer(1'b0, m, 8'h00);
    chk($sformatf("m%h", m), got, {8'h00, e});
  endtask : rd

  task cmd(input logic [7:0] op, input logic [9:0] m);
    wr(10'h077, m[7:0]);
    wr(10'h078, {6'h00, m[9:8]});
    wr(10'h076, op);
  endtask : cmd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_pointers;
    logic [9:0] a[5] = '{10'h001, 10'h003, 10'h004, 10'h00d, 10'h00e};
    logic [7:0] v[5] = '{8'ha5, 8'h5a, 8'h01, 8'h3c, 8'h01};
    for (int k = 0; k < 5; k++) wr(a[k], v[k]);
    for (int k = 0; k < 5; k++) rd(a[k], v[k]);
    cmd(`OP_INC, 10'h001);
    rd(10'h001, 8'ha6);
  endtask : t_pointers

  task t_ports;
    logic [9:0] a[6] = '{10'h000, 10'h002, 10'h00c, 10'h00a, 10'h040,
      10'h2c0};
    wr(10'h0a6, 8'h00);
    for (int k = 0; k < 6; k++) wr(a[k], 8'hff);
    for (int k = 0; k < 6; k++) rd(a[k], 8'h00);
    rd(10'h0a6, 8'h00);
  endtask : t_ports

  task t_indirect;
    wr(10'h090, 8'h11);
    wr(10'h001, 8'h90);
    cmd(`OP_LOAD, 10'h000);
    rd(10'h005, 8'h11);
    wr(10'h1a0, 8'h22);
    wr(10'h003, 8'ha0);
    cmd(`OP_INC, 10'h002);
    rd(10'h1a0, 8'h23);
    wr(10'h00d, 8'ha0);
    cmd(`OP_DEC, 10'h00c);
    rd(10'h1a0, 8'h22);
    cmd(`OP_ADD, 10'h1a0);
    rd(10'h005, 8'h11 + 8'h22);
    wr(10'h001, 8'hc0);
    cmd(`OP_STORE, 10'h000);
    rd(10'h0c0, 8'h11 + 8'h22);
    cmd(`OP_CLR, 10'h1a0);
    rd(10'h1a0, 8'h00);
    // sector 4 must not alias onto sector 0 through its low bits
    wr(10'h0a0, 8'h5c);
    wr(10'h004, 8'h04);
    cmd(`OP_STORE, 10'h002);
    rd(10'h0a0, 8'h5c);
    cmd(`OP_LOAD, 10'h002);
    rd(10'h005, 8'h00);
  endtask : t_indirect

  task t_table;
    wr(10'h007, 8'h34);
    wr(10'h009, 8'h12);
    #1;
    chk("tbl_addr", tbl_addr, 16'h1234);
    cmd(`OP_INC, 10'h007);
    rd(10'h007, 8'h35);
    cmd(`OP_TABRD, 10'h0c1);
    rd(10'h0c1, 8'h35 ^ 8'ha5);
    rd(10'h008, 8'h12 ^ 8'hc3);
    cmd(`OP_DEC, 10'h009);
    rd(10'h009, 8'h11);
  endtask : t_table

  task t_jump;
    wr(10'h006, 8'hf0);
    hi = pc[15:8];
    #1;
    chk("pc", pc, {hi, 8'hf0});
    chk("pc_dummy", {15'h0000, pc_dummy}, 16'h0001);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("pc", pc, {hi, 8'hf2});
  endtask : t_jump

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("pc", pc, 16'h0000);
    chk("tbl_addr", tbl_addr, 16'h0000);
    pc_advance <= 1'b1;
    t_pointers();
    t_ports();
    t_indirect();
    t_table();
    t_jump();
    conclude();
  end
endmodule : tb_top
